// ### include/pwctl_pkg.sv
// Constants, field layout and address decode for the password-gated register bank
`default_nettype none
package pwctl_pkg;
  // ----------------
  // Tables and addresses
  // ----------------
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] TBL_CONFIG = 8'h04;
  localparam logic [7:0] TBL_FACTORY = 8'h05;
  localparam logic [7:0] ADDR_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_PW_ENTRY = 8'h7B;
  localparam logic [7:0] ADDR_SAFETY_STATUS = 8'hB4;
  localparam logic [7:0] ADDR_MOD_PW_SET = 8'hB8;
  localparam logic [7:0] ADDR_HOST_PW_SET = 8'hBC;
  localparam logic [7:0] ADDR_TRIM_A = 8'h80;
  localparam logic [7:0] ADDR_TRIM_B = 8'h82;
  localparam logic [7:0] ADDR_THR_CODE = 8'h87;
  localparam logic [2:0] LEN_PW = 3'd4;
  localparam logic [2:0] LEN_TRIM = 3'd2;
  localparam logic [2:0] LEN_BYTE = 3'd1;
  // ----------------
  // Field positions
  // ----------------
  localparam int CTRL_OUT_A_BIT = 2;
  localparam int CTRL_OUT_B_BIT = 1;
  localparam int ST_BIAS_HIGH_BIT = 2;
  localparam int ST_TXP_HIGH_BIT = 3;
  localparam int ST_TXP_LOW_BIT = 4;
  localparam int ST_SHUTDOWN_BIT = 6;
  localparam int ST_SAFETY_BIT = 7;
  // ----------------
  // Values after reset and fixed read values
  // ----------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] THR_CODE_RESET = 8'h80;
  localparam logic [31:0] MOD_PW_RESET = 32'h00000000;
  localparam logic [31:0] HOST_PW_RESET = 32'h00000000;
  localparam logic [7:0] PW_ENTRY_BYTE_RESET = 8'hFF;
  localparam logic [15:0] TRIM_A_RESET = 16'h0000;
  localparam logic [15:0] TRIM_B_RESET = 16'h0000;
  localparam logic [7:0] HIDDEN_READ = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int THR_STEPS = 256;
  localparam int THR_FULL_SCALE_MV = 1000;

  typedef enum {STAGE_IDLE, STAGE_COLLECT, STAGE_BROKEN} stage_state_type;

  // Lower half is common to all tables; upper half needs the table match
  function automatic logic in_window(input logic [7:0] tsel, input logic [7:0] addr,
                                     input logic [7:0] tbl, input logic [7:0] base,
                                     input logic [2:0] len);
    logic [8:0] top;
    top = {1'b0, base} + {6'b000000, len};
    in_window = ((addr < UPPER_BASE) || (tsel == tbl)) && (addr >= base) &&
                ({1'b0, addr} < top);
  endfunction
endpackage
`default_nettype wire

// ### include/reg_port_if.sv
// Byte write channel shared by the register bank and its password gate
`timescale 1ns/1ps
`default_nettype none
interface reg_port_if;
  logic [7:0] table_sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic first;
  logic xact_end;
  modport source (
    output table_sel,
    output addr,
    output wdata,
    output wr,
    output first,
    output xact_end
  );
  modport sink (
    input table_sel,
    input addr,
    input wdata,
    input wr,
    input first,
    input xact_end
  );
endinterface
`default_nettype wire

// ### logic/safety_status_reg.sv
// Safety status byte: live quick-trip flags, shutdown flag, sticky fault flag
`timescale 1ns/1ps
`default_nettype none
module safety_status_reg (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bias_high_trip,
  input wire logic tx_power_high_trip,
  input wire logic tx_power_low_trip,
  input wire logic shutdown_mode,
  input wire logic laser_cutoff_gate,
  input wire logic fault_clear,
  output logic [7:0] status
);
  logic any_trip;
  logic safety_q;
  logic safety_d;
  logic [7:0] status_d;

  assign any_trip = bias_high_trip | tx_power_high_trip | tx_power_low_trip;
  assign safety_d = any_trip ? 1'b1 : (fault_clear ? 1'b0 : safety_q);

  always_comb begin
    status_d = 8'h00;
    status_d[pwctl_pkg::ST_BIAS_HIGH_BIT] = bias_high_trip;
    status_d[pwctl_pkg::ST_TXP_HIGH_BIT] = tx_power_high_trip;
    status_d[pwctl_pkg::ST_TXP_LOW_BIT] = tx_power_low_trip;
    status_d[pwctl_pkg::ST_SHUTDOWN_BIT] = shutdown_mode & laser_cutoff_gate;
    status_d[pwctl_pkg::ST_SAFETY_BIT] = safety_d;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      safety_q <= 1'b0;
      status <= pwctl_pkg::STATUS_RESET;
    end else begin
      safety_q <= safety_d;
      status <= status_d;
    end
  end
endmodule // safety_status_reg
`default_nettype wire

// ### logic/password_gate.sv
// Password entry, stored passwords, comparison and 4-byte password change
`timescale 1ns/1ps
`default_nettype none
module password_gate (
  input wire logic clk,
  input wire logic nrst,
  reg_port_if.sink port,
  output logic host_ok,
  output logic mod_ok,
  output logic change_refused
);
  logic [7:0] entry_q [4];
  logic [7:0] stage_q [4];
  logic [31:0] entry_word;
  logic [31:0] mod_pw_q;
  logic [31:0] host_pw_q;
  logic [2:0] cnt_q;
  logic tgt_mod_q;
  pwctl_pkg::stage_state_type state_q;
  logic [7:0] off;
  logic hit_entry;
  logic hit_mod;
  logic hit_host;
  logic hit_set;
  logic in_order;
  logic commit;
  logic granted;

  assign hit_entry = pwctl_pkg::in_window(port.table_sel, port.addr, pwctl_pkg::TBL_CONFIG,
                                          pwctl_pkg::ADDR_PW_ENTRY, pwctl_pkg::LEN_PW);
  assign hit_mod = pwctl_pkg::in_window(port.table_sel, port.addr, pwctl_pkg::TBL_CONFIG,
                                        pwctl_pkg::ADDR_MOD_PW_SET, pwctl_pkg::LEN_PW);
  assign hit_host = pwctl_pkg::in_window(port.table_sel, port.addr, pwctl_pkg::TBL_CONFIG,
                                         pwctl_pkg::ADDR_HOST_PW_SET, pwctl_pkg::LEN_PW);
  assign hit_set = hit_mod | hit_host;
  assign off = hit_entry ? (port.addr - pwctl_pkg::ADDR_PW_ENTRY) :
               (hit_mod ? (port.addr - pwctl_pkg::ADDR_MOD_PW_SET) :
               (port.addr - pwctl_pkg::ADDR_HOST_PW_SET));
  assign in_order = hit_set && (hit_mod == tgt_mod_q) && ({1'b0, off[1:0]} == cnt_q);
  assign granted = tgt_mod_q ? mod_ok : host_ok;
  // only a whole 4-byte write by an unlocked party lands
  assign commit = port.xact_end && (state_q == pwctl_pkg::STAGE_COLLECT) &&
                  (cnt_q == pwctl_pkg::LEN_PW) && granted;
  assign change_refused = port.xact_end && (state_q != pwctl_pkg::STAGE_IDLE) && !commit;
  assign entry_word = {entry_q[0], entry_q[1], entry_q[2], entry_q[3]};

  // each entry byte lands alone or within a burst
  for (genvar i = 0; i < 4; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (!nrst) begin
        entry_q[i] <= pwctl_pkg::PW_ENTRY_BYTE_RESET;
      end else if (port.wr && hit_entry && (off[1:0] == 2'(i))) begin
        entry_q[i] <= port.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= pwctl_pkg::STAGE_IDLE;
      cnt_q <= 3'd0;
      tgt_mod_q <= 1'b0;
    end else if (port.xact_end) begin
      state_q <= pwctl_pkg::STAGE_IDLE;
      cnt_q <= 3'd0;
    end else if (port.wr && port.first) begin
      state_q <= !hit_set ? pwctl_pkg::STAGE_IDLE :
                 (off[1:0] == 2'd0 ? pwctl_pkg::STAGE_COLLECT : pwctl_pkg::STAGE_BROKEN);
      cnt_q <= 3'd1;
      tgt_mod_q <= hit_mod;
    end else if (port.wr && state_q == pwctl_pkg::STAGE_COLLECT) begin
      state_q <= (in_order && cnt_q < pwctl_pkg::LEN_PW) ? pwctl_pkg::STAGE_COLLECT :
                 pwctl_pkg::STAGE_BROKEN;
      cnt_q <= cnt_q + 3'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (port.wr && hit_set) begin
      stage_q[off[1:0]] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mod_pw_q <= pwctl_pkg::MOD_PW_RESET;
      host_pw_q <= pwctl_pkg::HOST_PW_RESET;
    end else if (commit && tgt_mod_q) begin
      mod_pw_q <= {stage_q[0], stage_q[1], stage_q[2], stage_q[3]};
    end else if (commit) begin
      host_pw_q <= {stage_q[0], stage_q[1], stage_q[2], stage_q[3]};
    end
  end

  // access only while the full entry matches
  // a changed password locks until re-entered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mod_ok <= 1'b0;
      host_ok <= 1'b0;
    end else begin
      mod_ok <= (entry_word == mod_pw_q);
      host_ok <= (entry_word == host_pw_q);
    end
  end
endmodule // password_gate
`default_nettype wire

// ### logic/password_gated_control_registers.sv
// Register bank: safety status, password gate, sensor trims, conditioner control
`timescale 1ns/1ps
`default_nettype none
module password_gated_control_registers (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] table_sel,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic xact_first,
  input wire logic xact_end,
  input wire logic factory_mode,
  input wire logic power_down,
  input wire logic bias_sense_input_over,
  input wire logic tx_power_over,
  input wire logic tx_power_under,
  input wire logic shutdown_mode,
  input wire logic laser_cutoff_gate,
  input wire logic fault_clear,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic write_refused,
  output logic conditioner_out_a,
  output logic conditioner_out_b,
  output logic [7:0] threshold_voltage_code,
  output logic host_access,
  output logic module_access
);
  // ----------------
  // Declarations
  // ----------------
  // Write channel to the gate
  reg_port_if port ();

  // Control and code bytes
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] thr_code_q;
  logic [7:0] thr_code_d;

  // Factory trims
  logic [15:0] trim_a_q;
  logic [15:0] trim_b_q;

  // Safety status byte
  logic [7:0] status;

  // Read and refusal pulses
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic refused_q;
  logic refused_d;

  // Conditioner pins
  logic out_a_q;
  logic out_b_q;

  // Gate results
  logic host_ok;
  logic mod_ok;
  logic change_refused;

  // Address hits
  logic hit_ctrl;
  logic hit_status;
  logic hit_entry;
  logic hit_mod_set;
  logic hit_host_set;
  logic hit_trim_a;
  logic hit_trim_b;
  logic hit_thr;
  logic hit_hidden;
  logic trim_lo;

  // Write strobes
  logic wr_ctrl;
  logic wr_thr;
  logic wr_trim_a;
  logic wr_trim_b;
  logic wr_ro;

  // ----------------
  // Write channel into the shared port
  // ----------------
  // Gate decodes its own windows from these
  assign port.table_sel = table_sel;
  assign port.addr = reg_addr;
  assign port.wdata = reg_wdata;
  assign port.wr = reg_wr;
  assign port.first = xact_first;
  assign port.xact_end = xact_end;

  // ----------------
  // Address decode
  // ----------------
  assign hit_ctrl = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_CONFIG,
                                         pwctl_pkg::ADDR_CONTROL, pwctl_pkg::LEN_BYTE);

  assign hit_status = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_CONFIG,
                                           pwctl_pkg::ADDR_SAFETY_STATUS,
                                           pwctl_pkg::LEN_BYTE);

  assign hit_entry = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_CONFIG,
                                          pwctl_pkg::ADDR_PW_ENTRY, pwctl_pkg::LEN_PW);

  assign hit_mod_set = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_CONFIG,
                                            pwctl_pkg::ADDR_MOD_PW_SET, pwctl_pkg::LEN_PW);

  assign hit_host_set = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_CONFIG,
                                             pwctl_pkg::ADDR_HOST_PW_SET,
                                             pwctl_pkg::LEN_PW);

  assign hit_trim_a = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_FACTORY,
                                           pwctl_pkg::ADDR_TRIM_A, pwctl_pkg::LEN_TRIM);

  assign hit_trim_b = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_FACTORY,
                                           pwctl_pkg::ADDR_TRIM_B, pwctl_pkg::LEN_TRIM);

  assign hit_thr = pwctl_pkg::in_window(table_sel, reg_addr, pwctl_pkg::TBL_FACTORY,
                                        pwctl_pkg::ADDR_THR_CODE, pwctl_pkg::LEN_BYTE);

  assign hit_hidden = hit_entry | hit_mod_set | hit_host_set;
  // Trims are stored high byte first, so the odd address is the low byte
  assign trim_lo = reg_addr[0];

  // ----------------
  // Write qualification
  // ----------------
  assign wr_ctrl = reg_wr && hit_ctrl;
  assign wr_thr = reg_wr && hit_thr;

  assign wr_trim_a = reg_wr && hit_trim_a && factory_mode;
  assign wr_trim_b = reg_wr && hit_trim_b && factory_mode;

  assign wr_ro = reg_wr && (hit_status || ((hit_trim_a || hit_trim_b) && !factory_mode));

  // Password change refusals only show once the transaction ends
  assign refused_d = wr_ro || change_refused;

  // ----------------
  // Conditioner control byte
  // ----------------
  assign ctrl_d = wr_ctrl ? reg_wdata : ctrl_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= pwctl_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Outside power_down, pins follow the register a cycle later so they never glitch on decode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_a_q <= pwctl_pkg::CTRL_RESET[pwctl_pkg::CTRL_OUT_A_BIT];
      out_b_q <= pwctl_pkg::CTRL_RESET[pwctl_pkg::CTRL_OUT_B_BIT];
    end else if (power_down) begin
      out_a_q <= 1'b1;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= ctrl_q[pwctl_pkg::CTRL_OUT_A_BIT];
      out_b_q <= ctrl_q[pwctl_pkg::CTRL_OUT_B_BIT];
    end
  end

  assign conditioner_out_a = out_a_q;
  assign conditioner_out_b = out_b_q;

  // ----------------
  // Threshold voltage code
  // ----------------
  // Code n gives n/THR_STEPS of THR_FULL_SCALE_MV; the analog source does the scaling
  assign thr_code_d = wr_thr ? reg_wdata : thr_code_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      thr_code_q <= pwctl_pkg::THR_CODE_RESET;
    end else begin
      thr_code_q <= thr_code_d;
    end
  end

  assign threshold_voltage_code = thr_code_q;

  // ----------------
  // Factory scale trims
  // ----------------
  // Reset stands in for the nonvolatile load of the trimmed values
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_a_q <= pwctl_pkg::TRIM_A_RESET;
    end else if (wr_trim_a && trim_lo) begin
      trim_a_q[7:0] <= reg_wdata;
    end else if (wr_trim_a) begin
      trim_a_q[15:8] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_b_q <= pwctl_pkg::TRIM_B_RESET;
    end else if (wr_trim_b && trim_lo) begin
      trim_b_q[7:0] <= reg_wdata;
    end else if (wr_trim_b) begin
      trim_b_q[15:8] <= reg_wdata;
    end
  end

  // ----------------
  // Safety status and password gate
  // ----------------
  // Trip comparators sit outside; only their levels arrive here
  safety_status_reg u_status (
    .clk(clk),
    .nrst(nrst),
    .bias_high_trip(bias_sense_input_over),
    .tx_power_high_trip(tx_power_over),
    .tx_power_low_trip(tx_power_under),
    .shutdown_mode(shutdown_mode),
    .laser_cutoff_gate(laser_cutoff_gate),
    .fault_clear(fault_clear),
    .status(status)
  );

  // Gate keeps entry and both passwords away from the read mux
  password_gate u_gate (
    .clk(clk),
    .nrst(nrst),
    .port(port),
    .host_ok(host_ok),
    .mod_ok(mod_ok),
    .change_refused(change_refused)
  );

  assign host_access = host_ok;
  assign module_access = mod_ok;

  // ----------------
  // Read path
  // ----------------
  always_comb begin
    rdata_d = pwctl_pkg::UNMAPPED_READ;
    if (hit_hidden) begin
      rdata_d = pwctl_pkg::HIDDEN_READ;
    end else if (hit_ctrl) begin
      rdata_d = ctrl_q;
    end else if (hit_status) begin
      rdata_d = status;
    end else if (hit_trim_a) begin
      rdata_d = trim_lo ? trim_a_q[7:0] : trim_a_q[15:8];
    end else if (hit_trim_b) begin
      rdata_d = trim_lo ? trim_b_q[7:0] : trim_b_q[15:8];
    end else if (hit_thr) begin
      rdata_d = thr_code_q;
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= pwctl_pkg::UNMAPPED_READ;
      rvalid_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rdata_d : rdata_q;
      rvalid_q <= reg_rd;
      refused_q <= refused_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign write_refused = refused_q;
endmodule // password_gated_control_registers
`default_nettype wire

// ### dv/pwctl_chk.sv
// Port-level assertions for the password-gated register bank
`timescale 1ns/1ps
`default_nettype none
module pwctl_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] table_sel,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic xact_end,
  input wire logic factory_mode,
  input wire logic power_down,
  input wire logic bias_sense_input_over,
  input wire logic tx_power_over,
  input wire logic tx_power_under,
  input wire logic shutdown_mode,
  input wire logic laser_cutoff_gate,
  input wire logic [7:0] reg_rdata,
  input wire logic write_refused,
  input wire logic conditioner_out_a,
  input wire logic conditioner_out_b,
  input wire logic [7:0] threshold_voltage_code,
  input wire logic module_access
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire cfg_tbl = table_sel == pwctl_pkg::TBL_CONFIG;
  wire fac_tbl = table_sel == pwctl_pkg::TBL_FACTORY;
  wire st_sel = cfg_tbl && reg_addr == pwctl_pkg::ADDR_SAFETY_STATUS;
  wire pw_sel = (reg_addr >= 8'h7B && reg_addr <= 8'h7E) || (cfg_tbl && reg_addr >= 8'hB8);
  wire trip_any = bias_sense_input_over || tx_power_over || tx_power_under;
  // ----------------
  // Sequences
  // ----------------
  // Status lags its inputs by one cycle, the read by one more
  sequence s_st_rd;
    reg_rd && st_sel && $past(nrst);
  endsequence
  sequence s_ctrl_wr;
    reg_wr && reg_addr == 8'h01 ##1 !power_down;
  endsequence
  // ----------------
  // Properties
  // ----------------
  property p_st_live;
    s_st_rd |=> reg_rdata[4:2] == {$past(tx_power_under, 2), $past(tx_power_over, 2),
      $past(bias_sense_input_over, 2)} && reg_rdata[6] == $past(shutdown_mode && laser_cutoff_gate, 2);
  endproperty
  property p_safety;
    s_st_rd ##0 $past(trip_any) |=> reg_rdata[7];
  endproperty
  property p_hidden;
    reg_rd && pw_sel && (reg_addr < 8'hC0) |=> reg_rdata == 8'hFF;
  endproperty
  property p_pins;
    s_ctrl_wr |=> conditioner_out_a == $past(reg_wdata[2], 2) &&
      conditioner_out_b == $past(reg_wdata[1], 2);
  endproperty
  property p_pd;
    power_down |=> conditioner_out_a && !conditioner_out_b;
  endproperty
  property p_code;
    reg_wr && fac_tbl && reg_addr == 8'h87 |=> threshold_voltage_code == $past(reg_wdata);
  endproperty
  property p_code_rst;
    !$past(nrst) |-> threshold_voltage_code == 8'h80;
  endproperty
  property p_trim;
    reg_wr && fac_tbl && reg_addr[7:2] == 6'h20 && !factory_mode |=> write_refused;
  endproperty
  property p_acc;
    $changed(module_access) |-> $past(reg_wr, 2) || $past(xact_end, 2);
  endproperty
  a_st_live: assert property (p_st_live)
    else $error("status live bits wrong");
  a_safety: assert property (p_safety)
    else $error("safety flag not set");
  a_hidden: assert property (p_hidden)
    else $error("password byte readable");
  a_pins: assert property (p_pins)
    else $error("pins not following");
  a_pd: assert property (p_pd)
    else $error("pin override");
  a_code: assert property (p_code)
    else $error("threshold code not written");
  a_code_rst: assert property (p_code_rst)
    else $error("threshold code reset value");
  a_trim: assert property (p_trim)
    else $error("trim write not refused");
  a_acc: assert property (p_acc)
    else $error("access changed");
endmodule // pwctl_chk
bind password_gated_control_registers pwctl_chk pwctl_chk_inst (.clk(clk), .nrst(nrst),
  .table_sel(table_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .xact_end(xact_end), .factory_mode(factory_mode), .power_down(power_down),
  .bias_sense_input_over(bias_sense_input_over), .tx_power_over(tx_power_over),
  .tx_power_under(tx_power_under), .shutdown_mode(shutdown_mode),
  .laser_cutoff_gate(laser_cutoff_gate), .reg_rdata(reg_rdata), .write_refused(write_refused),
  .conditioner_out_a(conditioner_out_a), .conditioner_out_b(conditioner_out_b),
  .threshold_voltage_code(threshold_voltage_code), .module_access(module_access));
`default_nettype wire

// ### dv/host_bus_model.sv
// Host side of the register port: byte writes and byte reads
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic write_refused,
  output logic [7:0] table_sel,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic xact_first,
  output logic xact_end
);
  logic refused;
  logic got_valid;
  initial begin
    {table_sel, reg_addr, reg_wdata} = 24'h000000;
    {reg_wr, reg_rd, xact_first, xact_end} = 4'h0;
  end
  task automatic write_bytes(input logic [7:0] tsel, input logic [7:0] addr,
    input logic [31:0] data, input int n);
    refused = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      refused |= write_refused;
      table_sel = tsel;
      reg_addr = addr + i[7:0];
      reg_wdata = data[8 * (n - 1 - i) +: 8];
      reg_wr = 1'b1;
      xact_first = (i == 0);
    end
    @(posedge clk);
    #1;
    refused |= write_refused;
    {reg_wr, xact_first, xact_end} = 3'h1;
    @(posedge clk);
    #1;
    refused |= write_refused;
    xact_end = 1'b0;
  endtask
  task automatic read_byte(input logic [7:0] tsel, input logic [7:0] addr,
    output logic [7:0] data);
    @(posedge clk);
    #1;
    table_sel = tsel;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    got_valid = reg_rvalid;
    data = reg_rdata;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ### dv/test_password_gated_control_registers.sv
// Self-checking bench for the password-gated register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(N, E, G) \
  begin \
    samples_checked++; \
    if ((G) !== (E)) begin \
      failures++; \
      $display("BAD %s exp %h got %h", N, E, G); \
    end \
  end
module test_password_gated_control_registers;
  logic clk, nrst, factory_mode, power_down, fault_clear;
  logic bias_sense_input_over, tx_power_over, tx_power_under, shutdown_mode, laser_cutoff_gate;
  logic reg_wr, reg_rd, xact_first, xact_end, reg_rvalid, write_refused;
  logic conditioner_out_a, conditioner_out_b, host_access, module_access;
  logic [7:0] table_sel, reg_addr, reg_wdata, reg_rdata, threshold_voltage_code;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] codes [3] = '{8'h00, 8'h01, 8'hFF};
  logic [7:0] ctrl [4] = '{8'h04, 8'h02, 8'h06, 8'h00};
  logic [4:0] st_in [5] = '{5'h10, 5'h08, 5'h04, 5'h03, 5'h02};
  logic [7:0] st_exp [5] = '{8'h84, 8'h88, 8'h90, 8'hC0, 8'h80};
  password_gated_control_registers password_gated_control_registers_inst (.clk(clk),
    .nrst(nrst), .table_sel(table_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .xact_first(xact_first), .xact_end(xact_end),
    .factory_mode(factory_mode), .power_down(power_down),
    .bias_sense_input_over(bias_sense_input_over), .tx_power_over(tx_power_over),
    .tx_power_under(tx_power_under), .shutdown_mode(shutdown_mode),
    .laser_cutoff_gate(laser_cutoff_gate), .fault_clear(fault_clear), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .write_refused(write_refused),
    .conditioner_out_a(conditioner_out_a), .conditioner_out_b(conditioner_out_b),
    .threshold_voltage_code(threshold_voltage_code), .host_access(host_access),
    .module_access(module_access));
  host_bus_model host_bus_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .write_refused(write_refused), .table_sel(table_sel), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .xact_first(xact_first),
    .xact_end(xact_end));
  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] tsel, input logic [7:0] addr, input logic [7:0] e,
    input string nm);
    logic [7:0] v;
    host_bus_model_inst.read_byte(tsel, addr, v);
    `CHECK(nm, 1'b1, host_bus_model_inst.got_valid)
    `CHECK(nm, e, v)
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    {nrst, factory_mode, power_down, fault_clear} = 4'h0;
    {bias_sense_input_over, tx_power_over, tx_power_under} = 3'h0;
    {shutdown_mode, laser_cutoff_gate} = 2'h0;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    // ----------------
    // Threshold code and conditioner pins
    // ----------------
    rd_chk(8'h05, 8'h87, 8'h80, "code_rst");
    for (int i = 0; i < 3; i++) begin
      host_bus_model_inst.write_bytes(8'h05, 8'h87, {24'h000000, codes[i]}, 1);
      rd_chk(8'h05, 8'h87, codes[i], "code");
      `CHECK("code_out", codes[i], threshold_voltage_code)
    end
    for (int i = 0; i < 4; i++) begin
      host_bus_model_inst.write_bytes(8'h00, 8'h01, {24'h000000, ctrl[i]}, 1);
      @(posedge clk);
      #1;
      `CHECK("pins", ctrl[i][2:1], {conditioner_out_a, conditioner_out_b})
    end
    power_down = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHECK("pins_pd", 2'h2, {conditioner_out_a, conditioner_out_b})
    power_down = 1'b0;
    $display("test control done");
    // ----------------
    // Sensor scale trims
    // ----------------
    host_bus_model_inst.write_bytes(8'h05, 8'h80, 32'h0000A55A, 2);
    `CHECK("trim_ref", 1'b1, host_bus_model_inst.refused)
    rd_chk(8'h05, 8'h80, 8'h00, "trim_kept");
    factory_mode = 1'b1;
    host_bus_model_inst.write_bytes(8'h05, 8'h80, 32'hA55A3CC3, 4);
    factory_mode = 1'b0;
    `CHECK("trim_ok", 1'b0, host_bus_model_inst.refused)
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h05, 8'h80 + i[7:0], 8'(32'hA55A3CC3 >> (24 - 8 * i)), "trim");
    end
    $display("test trims done");
    // ----------------
    // Safety status
    // ----------------
    rd_chk(8'h04, 8'hB4, 8'h00, "status0");
    for (int i = 0; i < 5; i++) begin
      {bias_sense_input_over, tx_power_over, tx_power_under} = st_in[i][4:2];
      {shutdown_mode, laser_cutoff_gate} = st_in[i][1:0];
      rd_chk(8'h04, 8'hB4, st_exp[i], "status");
    end
    {shutdown_mode, laser_cutoff_gate, fault_clear} = 3'h1;
    @(posedge clk);
    #1;
    fault_clear = 1'b0;
    rd_chk(8'h04, 8'hB4, 8'h00, "status_clr");
    $display("test status done");
    // ----------------
    // Passwords
    // ----------------
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h04, 8'h7B + i[7:0], 8'hFF, "pw_entry");
      rd_chk(8'h04, 8'hB8 + i[7:0], 8'hFF, "pw_mod");
      rd_chk(8'h04, 8'hBC + i[7:0], 8'hFF, "pw_host");
    end
    for (int i = 0; i < 4; i++) begin
      host_bus_model_inst.write_bytes(8'h04, 8'h7B + i[7:0], 32'h00000000, 1);
      `CHECK("mod_part", (i == 3), module_access)
    end
    `CHECK("host_acc", 1'b1, host_access)
    host_bus_model_inst.write_bytes(8'h04, 8'hB8, 32'hA5C30F96, 4);
    `CHECK("chg_ok", 1'b0, host_bus_model_inst.refused)
    repeat (2) @(posedge clk);
    #1;
    `CHECK("mod_lost", 2'h2, {host_access, module_access})
    host_bus_model_inst.write_bytes(8'h04, 8'h7B, 32'hA5C30F96, 4);
    `CHECK("mod_back", 2'h1, {host_access, module_access})
    rd_chk(8'h04, 8'hB8, 8'hFF, "pw_mod_new");
    host_bus_model_inst.write_bytes(8'h04, 8'hB8, 32'h00123456, 3);
    `CHECK("chg_short", 1'b1, host_bus_model_inst.refused)
    repeat (2) @(posedge clk);
    #1;
    `CHECK("mod_keep", 1'b1, module_access)
    $display("test passwords done");
    finish_test();
  end
endmodule // test_password_gated_control_registers
`default_nettype wire
